// >>> logic/fdsft_pkg.sv
// Shared constants for the FSK divider select and frequency trim block.
// Assumes a 32-bit AXI4-Lite register bus and a single 200 MHz clock.
package fdsft_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int IDX_W = 7;

  // ****************************************************************
  // Field widths
  // ****************************************************************
  localparam int MAIN_W = 12;
  localparam int REF_W = 10;
  localparam int SWAL_W = 7;
  localparam int TRIM_W = 8;
  localparam int FEE_W = 8;
  localparam int FEE_CTRL_W = 4;
  localparam int SYM_W = 7;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [IDX_W-1:0] IDX_CTRL = 7'h00;
  localparam logic [IDX_W-1:0] IDX_MAIN0 = 7'h01;
  localparam logic [IDX_W-1:0] IDX_REF0 = 7'h02;
  localparam logic [IDX_W-1:0] IDX_SWAL0 = 7'h03;
  localparam logic [IDX_W-1:0] IDX_MAIN1 = 7'h04;
  localparam logic [IDX_W-1:0] IDX_REF1 = 7'h05;
  localparam logic [IDX_W-1:0] IDX_SWAL1 = 7'h06;
  localparam logic [IDX_W-1:0] IDX_TRIM = 7'h07;
  localparam logic [IDX_W-1:0] IDX_STATUS = 7'h08;
  localparam logic [IDX_W-1:0] IDX_FEE_CTRL = 7'h15;
  localparam logic [IDX_W-1:0] IDX_FEE_RESULT = 7'h16;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_TX_BIT = 0;
  localparam int FEE_MODE_LSB = 0;
  localparam int FEE_LEN_LSB = 2;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_DATA_BIT = 2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [MAIN_W-1:0] MAIN_RST = 12'h000;
  localparam logic [REF_W-1:0] REF_RST = 10'h000;
  localparam logic [SWAL_W-1:0] SWAL_RST = 7'h00;
  localparam logic [TRIM_W-1:0] TRIM_RST = 8'h80;
  localparam logic [FEE_CTRL_W-1:0] FEE_CTRL_RST = 4'h0;

  // ****************************************************************
  // Estimator modes and measurement length
  // ****************************************************************
  typedef enum logic [1:0] {
    FEE_OFF = 2'h0,
    FEE_UP = 2'h1,
    FEE_DN = 2'h2,
    FEE_UPDN = 2'h3
  } fdsft_fee_mode_t;

  localparam logic [SYM_W-1:0] FEE_BASE_SYMBOLS = 7'h08;

  // ****************************************************************
  // Bus responses
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : fdsft_pkg

// >>> logic/fdsft_fee_counter.sv
// Frequency error estimator counter: counts demodulator up/down pulses.
// Assumes pulses and symbol strobe are one-cycle, synchronous to ref_clk.
`timescale 1ns/10ps
module fdsft_fee_counter
  import fdsft_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control from the register file
  input wire logic [1:0] feeMode,
  input wire logic [1:0] feeLen,
  input wire logic feeStart,
  // Demodulator events
  input wire logic upPulse,
  input wire logic dnPulse,
  input wire logic symbolStrobe,
  // Result
  output logic [fdsft_pkg::FEE_W-1:0] freqErrorEstimate,
  output logic feeBusy,
  output logic feeDone
);
  import fdsft_pkg::*;

  typedef enum logic {ST_IDLE, ST_COUNT} fdsft_fee_state_t;

  fdsft_fee_state_t state, next_state;
  logic [FEE_W-1:0] count, next_count;
  logic [SYM_W-1:0] symCnt, next_symCnt;
  logic [FEE_W-1:0] next_freqErrorEstimate;
  logic next_feeDone;
  logic [SYM_W-1:0] symTarget;
  logic [FEE_W-1:0] stepped;

  // Measurement length: 8, 16, 32 or 64 symbols
  assign symTarget = SYM_W'(FEE_BASE_SYMBOLS << feeLen);

  // Signed step; plain 8-bit arithmetic so the count wraps, never saturates
  always_comb begin
    stepped = count;
    if (feeMode[0] && upPulse) begin
      stepped = FEE_W'(stepped + 8'h01);
    end
    if (feeMode[1] && dnPulse) begin
      stepped = FEE_W'(stepped - 8'h01);
    end
  end

  // Next state of the measurement
  always_comb begin
    next_state = state;
    next_count = count;
    next_symCnt = symCnt;
    next_freqErrorEstimate = freqErrorEstimate;
    next_feeDone = feeDone;
    case (state)
      ST_IDLE: begin
        if (feeStart && feeMode != FEE_OFF) begin
          next_state = ST_COUNT;
          next_count = '0;
          next_symCnt = '0;
          next_feeDone = 1'b0;
        end
      end
      ST_COUNT: begin
        next_count = stepped;
        if (symbolStrobe) begin
          next_symCnt = SYM_W'(symCnt + 7'h01);
        end
        if (feeStart) begin
          // A new start restarts the window rather than queueing
          next_count = '0;
          next_symCnt = '0;
          next_state = (feeMode != FEE_OFF) ? ST_COUNT : ST_IDLE;
        end else if (symbolStrobe && next_symCnt == symTarget) begin
          next_freqErrorEstimate = stepped;
          next_feeDone = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      count <= '0;
      symCnt <= '0;
      freqErrorEstimate <= '0;
      feeDone <= 1'b0;
      feeBusy <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      symCnt <= next_symCnt;
      freqErrorEstimate <= next_freqErrorEstimate;
      feeDone <= next_feeDone;
      feeBusy <= (next_state == ST_COUNT);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  fee_wrap_a: assert property (
    (state == ST_COUNT && !feeStart && !symbolStrobe && feeMode[1] && dnPulse
      && !(feeMode[0] && upPulse) && count == 8'h80) |=> count == 8'h7F)
    else $error("Error count did not wrap from -128 to +127");

  fee_updn_a: assert property (
    (state == ST_COUNT && !feeStart && !symbolStrobe && feeMode == FEE_UPDN
      && upPulse && !dnPulse) |=> count == $past(count) + 8'h01)
    else $error("Up pulse did not raise the error count by one");

  fee_result_a: assert property (
    $rose(feeDone) |-> freqErrorEstimate == $past(stepped))
    else $error("Latched estimate differs from final count");

endmodule : fdsft_fee_counter

// >>> logic/fdsft_top.sv
// FSK divider set selection, serial data pin steering and crystal trim.
// Assumes an AXI4-Lite master on ref_clk and all pins synchronous to it.
`timescale 1ns/10ps
module fdsft_top
  import fdsft_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // AXI4-Lite write channels
  input wire logic [fdsft_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [fdsft_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [fdsft_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [fdsft_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [fdsft_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial data pin
  input wire logic serialBitIn,
  output logic serialBitOut,
  output logic serialBitOe,
  // Demodulator side
  input wire logic rxDemodBit,
  input wire logic feeUpPulse,
  input wire logic feeDnPulse,
  input wire logic feeSymbolStrobe,
  // Synthesizer dividers and trim
  output logic [fdsft_pkg::MAIN_W-1:0] synthMainDiv,
  output logic [fdsft_pkg::REF_W-1:0] synthRefDiv,
  output logic [fdsft_pkg::SWAL_W-1:0] synthSwallowDiv,
  output logic synthSetOne,
  output logic [fdsft_pkg::TRIM_W-1:0] crystalTrimCode
);
  import fdsft_pkg::*;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic [IDX_W-1:0] regIndex(input logic [ADDR_W-1:0] addr);
    return addr[ADDR_W-1:2];
  endfunction : regIndex

  function automatic logic isMapped(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_CTRL, IDX_MAIN0, IDX_REF0, IDX_SWAL0, IDX_MAIN1, IDX_REF1, IDX_SWAL1,
      IDX_TRIM, IDX_STATUS, IDX_FEE_CTRL, IDX_FEE_RESULT: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : isMapped

  function automatic logic [DATA_W-1:0] mergeBytes(
    input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] wd,
    input logic [STRB_W-1:0] st
  );
    logic [DATA_W-1:0] m;
    m = old;
    for (int i = 0; i < STRB_W; i++) begin
      if (st[i]) begin
        m[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return m;
  endfunction : mergeBytes

  // ****************************************************************
  // Register file state
  // ****************************************************************
  logic txMode, next_txMode;
  logic [MAIN_W-1:0] mainDiv [2];
  logic [REF_W-1:0] refDiv [2];
  logic [SWAL_W-1:0] swalDiv [2];
  logic [MAIN_W-1:0] next_mainDiv [2];
  logic [REF_W-1:0] next_refDiv [2];
  logic [SWAL_W-1:0] next_swalDiv [2];
  logic [TRIM_W-1:0] next_crystalTrimCode;
  logic [FEE_CTRL_W-1:0] feeCtrl, next_feeCtrl;
  logic feeStart, next_feeStart;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [DATA_W-1:0] next_rdata, readWord, oldWord, newWord;
  logic [IDX_W-1:0] wrIdx, rdIdx;
  logic wrFire, rdFire, wrSet;
  logic [FEE_W-1:0] freqErrorEstimate;
  logic feeBusy, feeDone;

  // Divider path state
  logic dataBit, next_dataBit;
  logic [MAIN_W-1:0] next_synthMainDiv;
  logic [REF_W-1:0] next_synthRefDiv;
  logic [SWAL_W-1:0] next_synthSwallowDiv;
  logic next_synthSetOne, next_serialBitOut, next_serialBitOe;

  assign wrIdx = regIndex(s_axi_awaddr);
  assign rdIdx = regIndex(s_axi_araddr);
  // Address and data are accepted together, so one handshake term suffices
  assign wrFire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rdFire = s_axi_arvalid && s_axi_arready;
  // Divider indices 1..3 are the zero set, 4..6 the one set
  assign wrSet = (wrIdx >= IDX_MAIN1);

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // Current value of the word addressed by the read port, for read data
  always_comb begin
    readWord = '0;
    case (rdIdx)
      IDX_CTRL: readWord[CTRL_TX_BIT] = txMode;
      IDX_MAIN0: readWord[MAIN_W-1:0] = mainDiv[0];
      IDX_REF0: readWord[REF_W-1:0] = refDiv[0];
      IDX_SWAL0: readWord[SWAL_W-1:0] = swalDiv[0];
      IDX_MAIN1: readWord[MAIN_W-1:0] = mainDiv[1];
      IDX_REF1: readWord[REF_W-1:0] = refDiv[1];
      IDX_SWAL1: readWord[SWAL_W-1:0] = swalDiv[1];
      IDX_TRIM: readWord[TRIM_W-1:0] = crystalTrimCode;
      IDX_STATUS: begin
        readWord[STAT_DONE_BIT] = feeDone;
        readWord[STAT_BUSY_BIT] = feeBusy;
        readWord[STAT_DATA_BIT] = dataBit;
      end
      IDX_FEE_CTRL: readWord[FEE_CTRL_W-1:0] = feeCtrl;
      IDX_FEE_RESULT: readWord[FEE_W-1:0] = freqErrorEstimate;
      default: readWord = '0;
    endcase
  end

  // Old value seen by the write port, merged under the byte strobes
  always_comb begin
    oldWord = '0;
    case (wrIdx)
      IDX_CTRL: oldWord[CTRL_TX_BIT] = txMode;
      IDX_MAIN0, IDX_MAIN1: oldWord[MAIN_W-1:0] = mainDiv[wrSet];
      IDX_REF0, IDX_REF1: oldWord[REF_W-1:0] = refDiv[wrSet];
      IDX_SWAL0, IDX_SWAL1: oldWord[SWAL_W-1:0] = swalDiv[wrSet];
      IDX_TRIM: oldWord[TRIM_W-1:0] = crystalTrimCode;
      IDX_FEE_CTRL: oldWord[FEE_CTRL_W-1:0] = feeCtrl;
      default: oldWord = '0;
    endcase
    newWord = mergeBytes(oldWord, s_axi_wdata, s_axi_wstrb);
  end

  // ****************************************************************
  // Bus handshakes and register writes
  // ****************************************************************
  // Ready is raised only once both write halves wait and no response is pending
  always_comb begin
    next_awready = !s_axi_awready && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    next_wready = next_awready;
    next_bvalid = s_axi_bvalid ? !s_axi_bready : wrFire;
    next_bresp = wrFire ? (isMapped(wrIdx) ? RESP_OKAY : RESP_SLVERR) : s_axi_bresp;
    next_arready = !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
    next_rvalid = s_axi_rvalid ? !s_axi_rready : rdFire;
    next_rdata = rdFire ? readWord : s_axi_rdata;
    next_rresp = rdFire ? (isMapped(rdIdx) ? RESP_OKAY : RESP_SLVERR) : s_axi_rresp;
    next_txMode = txMode;
    next_mainDiv = mainDiv;
    next_refDiv = refDiv;
    next_swalDiv = swalDiv;
    next_crystalTrimCode = crystalTrimCode;
    next_feeCtrl = feeCtrl;
    next_feeStart = 1'b0;
    if (wrFire) begin
      case (wrIdx)
        IDX_CTRL: next_txMode = newWord[CTRL_TX_BIT];
        IDX_MAIN0, IDX_MAIN1: next_mainDiv[wrSet] = newWord[MAIN_W-1:0];
        IDX_REF0, IDX_REF1: next_refDiv[wrSet] = newWord[REF_W-1:0];
        IDX_SWAL0, IDX_SWAL1: next_swalDiv[wrSet] = newWord[SWAL_W-1:0];
        IDX_TRIM: next_crystalTrimCode = newWord[TRIM_W-1:0];
        IDX_FEE_CTRL: begin
          // Writing the control word with byte 0 strobed also arms a fresh measurement
          next_feeCtrl = newWord[FEE_CTRL_W-1:0];
          next_feeStart = s_axi_wstrb[0];
        end
        default: next_txMode = txMode; // Result and status are read only
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
      txMode <= 1'b0;
      mainDiv <= '{MAIN_RST, MAIN_RST};
      refDiv <= '{REF_RST, REF_RST};
      swalDiv <= '{SWAL_RST, SWAL_RST};
      crystalTrimCode <= TRIM_RST;
      feeCtrl <= FEE_CTRL_RST;
      feeStart <= 1'b0;
    end else begin
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      txMode <= next_txMode;
      mainDiv <= next_mainDiv;
      refDiv <= next_refDiv;
      swalDiv <= next_swalDiv;
      crystalTrimCode <= next_crystalTrimCode;
      feeCtrl <= next_feeCtrl;
      feeStart <= next_feeStart;
    end
  end

  // ****************************************************************
  // Divider set selection and data pin direction
  // ****************************************************************
  // Receive holds the zero set, which carries the receive injection frequency
  always_comb begin
    next_dataBit = txMode ? serialBitIn : 1'b0;
    next_synthSetOne = dataBit;
    next_synthMainDiv = mainDiv[dataBit];
    next_synthRefDiv = refDiv[dataBit];
    next_synthSwallowDiv = swalDiv[dataBit];
    next_serialBitOe = !txMode;
    next_serialBitOut = rxDemodBit;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dataBit <= 1'b0;
      synthSetOne <= 1'b0;
      synthMainDiv <= MAIN_RST;
      synthRefDiv <= REF_RST;
      synthSwallowDiv <= SWAL_RST;
      serialBitOe <= 1'b1;
      serialBitOut <= 1'b0;
    end else begin
      dataBit <= next_dataBit;
      synthSetOne <= next_synthSetOne;
      synthMainDiv <= next_synthMainDiv;
      synthRefDiv <= next_synthRefDiv;
      synthSwallowDiv <= next_synthSwallowDiv;
      serialBitOe <= next_serialBitOe;
      serialBitOut <= next_serialBitOut;
    end
  end

  // ****************************************************************
  // Frequency error estimator
  // ****************************************************************
  fdsft_fee_counter feeCounter (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .feeMode(feeCtrl[FEE_MODE_LSB +: 2]),
    .feeLen(feeCtrl[FEE_LEN_LSB +: 2]),
    .feeStart(feeStart),
    .upPulse(feeUpPulse),
    .dnPulse(feeDnPulse),
    .symbolStrobe(feeSymbolStrobe),
    .freqErrorEstimate(freqErrorEstimate),
    .feeBusy(feeBusy),
    .feeDone(feeDone)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence txBitRise;
    txMode && !dataBit ##1 txMode && dataBit && $stable(mainDiv[1]);
  endsequence

  zero_set_a: assert property (
    ($past(txMode) && !$past(dataBit)) |-> synthMainDiv == $past(mainDiv[0])
      && synthRefDiv == $past(refDiv[0]) && synthSwallowDiv == $past(swalDiv[0]))
    else $error("Zero bit did not load the zero divider set");

  one_set_a: assert property (
    ($past(txMode) && $past(dataBit)) |-> synthMainDiv == $past(mainDiv[1])
      && synthRefDiv == $past(refDiv[1]) && synthSwallowDiv == $past(swalDiv[1]))
    else $error("One bit did not load the one divider set");

  set_switch_a: assert property (
    txBitRise |=> synthSetOne && synthMainDiv == $past(mainDiv[1]))
    else $error("Divider set did not switch on a rising data bit");

  bit_follow_a: assert property (
    $past(txMode) |-> dataBit == $past(serialBitIn))
    else $error("Selected bit does not follow the sampled pin");

  pin_dir_a: assert property (
    serialBitOe == !$past(txMode))
    else $error("Data pin direction does not match the mode");

  result_read_a: assert property (
    (rdFire && rdIdx == IDX_FEE_RESULT) |=> s_axi_rvalid
      && s_axi_rdata == {24'h000000, $past(freqErrorEstimate)})
    else $error("Error result read back wrongly");

endmodule : fdsft_top

// >>> sim/fdsft_host_model.sv
// Host-side model: drives the serial pin in transmit and the demodulator events.
// Assumes a pull-up on the pin, so a released line reads high.
`timescale 1ns/10ps
module fdsft_host_model (
  // Clock and pin
  input wire logic ref_clk,
  input wire logic serialBitOut,
  input wire logic serialBitOe,
  output logic serialBitIn,
  // Demodulator events
  output logic rxDemodBit,
  output logic feeUpPulse,
  output logic feeDnPulse,
  output logic feeSymbolStrobe
);
  logic hostBit;
  logic hostTx;
  // Wire level from both enables; nobody driving leaves the pull-up
  assign serialBitIn = serialBitOe ? serialBitOut : (hostTx ? hostBit : 1'b1);
  // Idle levels from time zero
  initial begin
    hostBit = 1'b0;
    hostTx = 1'b0;
    rxDemodBit = 1'b0;
    feeUpPulse = 1'b0;
    feeDnPulse = 1'b0;
    feeSymbolStrobe = 1'b0;
  end
  // Pulses first (paired ones cancel in up/down mode), then eight symbol strobes
  task automatic burst(input int nUp, input int nDn);
    for (int i = 0; i < nUp || i < nDn; i++) begin
      @(posedge ref_clk);
      feeUpPulse <= (i < nUp);
      feeDnPulse <= (i < nDn);
    end
    @(posedge ref_clk);
    feeUpPulse <= 1'b0;
    feeDnPulse <= 1'b0;
    repeat (8) begin
      @(posedge ref_clk);
      feeSymbolStrobe <= 1'b1;
      @(posedge ref_clk);
      feeSymbolStrobe <= 1'b0;
    end
  endtask : burst
endmodule : fdsft_host_model

// >>> sim/fsk_divider_select_freq_trim_tb.sv
// Testbench for the divider select and trim block, with AXI4-Lite tasks.
// Assumes the host model drives the pin and demodulator events.
`timescale 1ns/10ps
module fsk_divider_select_freq_trim_tb;
  import fdsft_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [STRB_W-1:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic serialBitIn, serialBitOut, serialBitOe, rxDemodBit;
  logic feeUpPulse, feeDnPulse, feeSymbolStrobe, synthSetOne;
  logic [MAIN_W-1:0] synthMainDiv;
  logic [REF_W-1:0] synthRefDiv;
  logic [SWAL_W-1:0] synthSwallowDiv;
  logic [TRIM_W-1:0] crystalTrimCode;
  logic [31:0] d;
  int errors = 0, checks = 0;

  fdsft_top dut (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serialBitIn,
    .serialBitOut, .serialBitOe, .rxDemodBit, .feeUpPulse, .feeDnPulse,
    .feeSymbolStrobe, .synthMainDiv, .synthRefDiv, .synthSwallowDiv, .synthSetOne,
    .crystalTrimCode);
  fdsft_host_model host (.ref_clk, .serialBitOut, .serialBitOe, .serialBitIn,
    .rxDemodBit, .feeUpPulse, .feeDnPulse, .feeSymbolStrobe);

  // Free-running clock
  always #2.5 ref_clk = ~ref_clk;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  // Address and data offered together, each released when taken
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] wd);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(a && w)) begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1) begin
        a = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // Idle edge so a following call never re-raises bready in this step
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [IDX_W-1:0] idx);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    // Idle edge so back-to-back reads never assign rready twice at once
    @(posedge ref_clk);
  endtask : rd

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset();
    check("trim reset", crystalTrimCode, TRIM_RST);
    check("pin driven in receive", serialBitOe, 1'b1);
    check("zero set at reset", synthSetOne, 1'b0);
  endtask : test_reset

  // Both sets loaded, then the pin level picks one set whole
  task automatic test_sets();
    wr(IDX_MAIN0, 32'h123);
    wr(IDX_REF0, 32'h045);
    wr(IDX_SWAL0, 32'h11);
    wr(IDX_MAIN1, 32'hABC);
    wr(IDX_REF1, 32'h3C3);
    wr(IDX_SWAL1, 32'h6E);
    host.hostTx <= 1'b1;
    wr(IDX_CTRL, 32'h1);
    for (int b = 0; b < 3; b++) begin
      host.hostBit <= b[0];
      repeat (6) @(posedge ref_clk);
      check("pin released in transmit", serialBitOe, 1'b0);
      check("set flag", synthSetOne, b[0]);
      check("main", synthMainDiv, b[0] ? 12'hABC : 12'h123);
      check("ref", synthRefDiv, b[0] ? 10'h3C3 : 10'h045);
      check("swallow", synthSwallowDiv, b[0] ? 7'h6E : 7'h11);
    end
  endtask : test_sets

  // Receive: device drives the pin from the demodulator
  task automatic test_rx();
    host.hostTx <= 1'b0;
    wr(IDX_CTRL, 32'h0);
    for (int b = 1; b >= 0; b--) begin
      host.rxDemodBit <= b[0];
      repeat (4) @(posedge ref_clk);
      check("pin driven", serialBitOe, 1'b1);
      check("pin level", serialBitIn, b[0]);
      check("pin output", serialBitOut, b[0]);
    end
  endtask : test_rx

  // One measurement over eight symbols, result read back as a byte
  task automatic test_fee(input logic [1:0] mode, input int nUp, input int nDn,
      input logic [7:0] exp);
    wr(IDX_FEE_CTRL, {30'h0, mode});
    host.burst(nUp, nDn);
    do rd(IDX_STATUS); while (d[STAT_DONE_BIT] !== 1'b1);
    rd(IDX_FEE_RESULT);
    check("estimate", d, {24'h0, exp});
  endtask : test_fee

  // Measure, lower the trim on a positive error, then measure once more, expecting balance
  task automatic test_trim_loop();
    logic [7:0] trim;
    trim = TRIM_RST;
    for (int n = 0; n < 2; n++) begin
      test_fee(FEE_UPDN, 4, 3 + n, n ? 8'h00 : 8'h01);
      if ($signed(d[7:0]) > 0) begin
        trim = trim - 8'h01;
        wr(IDX_TRIM, {24'h0, trim});
      end
    end
    check("trim after loop", crystalTrimCode, TRIM_RST - 8'h01);
  endtask : test_trim_loop

  task automatic test_bus();
    wr(7'h40, 32'h1);
    check("unmapped write", r, RESP_SLVERR);
    rd(7'h40);
    check("unmapped read", r, RESP_SLVERR);
    wr(IDX_TRIM, 32'h7F);
    check("trim lowered", crystalTrimCode, 8'h7F);
    rd(IDX_TRIM);
    check("trim read", d, 32'h7F);
  endtask : test_bus

  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    test_reset();
    test_sets();
    test_rx();
    test_fee(FEE_UP, 5, 3, 8'h05);
    test_fee(FEE_DN, 5, 3, 8'hFD);
    test_fee(FEE_UPDN, 5, 3, 8'h02);
    test_fee(FEE_UPDN, 0, 129, 8'h7F);
    test_trim_loop();
    test_bus();
    stop_test();
  end

  // Watchdog, far beyond the expected run length
  initial begin
    #400000;
    errors++;
    stop_test();
  end
endmodule : fsk_divider_select_freq_trim_tb
